/* token_pkg.sv */
`default_nettype none
package token_pkg;
  // token space geometry
  localparam int          TOKEN_COUNT    = 8;
  localparam int          TOKEN_ADDR_W   = 3;
  localparam int          DATA_W         = 8;
  localparam int          FLAG_BIT       = 0;
  // pin phase timing in clock cycles at 25 MHz
  localparam int          SETUP_CYC      = 1;
  localparam int          STROBE_CYC     = 2;
  localparam int          GAP_CYC        = 1;
  localparam logic [1:0]  CNT_ZERO       = 2'h0;
  // command codes from the user side
  localparam logic [1:0]  CMD_CLAIM      = 2'h0;
  localparam logic [1:0]  CMD_RELEASE    = 2'h1;
  localparam logic [1:0]  CMD_INIT       = 2'h2;
  localparam logic [1:0]  CMD_PROBE      = 2'h3;

  typedef struct packed {
    logic [1:0]              cmd;
    logic [TOKEN_ADDR_W-1:0] token;
  } request_s;

  typedef struct packed {
    logic                    token_space_select_n;
    logic                    write_n;
    logic                    output_enable_n;
    logic [TOKEN_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]       data;
    logic                    data_oe;
  } pins_s;

  typedef struct packed {
    logic                    owned;
    logic                    done;
  } answer_s;
endpackage
`default_nettype wire

/* token_host.sv */
// Behaviour
// RULE1 - device grants a contested free token to exactly one port
// RULE2 - earlier claim wins the token
// RULE3 - simultaneous claims settle on one arbitrary port
// RULE4 - token latches start undefined; device does not initialise them
// RULE5 - host writes one into every token after reset
// RULE6 - claim is write zero then read back; zero read means owned
// RULE7 - host releases an owned token by writing one
// RULE8 - after a failed claim host withdraws its request by writing one
// RULE9 - eight independent tokens, each addressed separately
// RULE10 - writes use data bit zero only; flags read active low
// RULE11 - token space picked by select low; address bits 2..0 choose token
// RULE12 - device spreads flag onto all bits, latched during select and read
// RULE13 - release hands token straight to a pending other-port claim
// RULE14 - owner reads zero while the other port reads one
`timescale 1ns/1ps
`default_nettype none
module token_host (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_i,
  // user command port
  input  wire logic                    req_valid_i,
  input  wire token_pkg::request_s     req_i,
  output logic                         req_ready_o,
  output token_pkg::answer_s           answer_o,
  output logic                         init_done_o,
  // device pins
  output token_pkg::pins_s             pins_o,
  input  wire logic [token_pkg::DATA_W-1:0] data_i
);
  // ==========================================================
  // state machine
  typedef enum logic [5:0] {
    S_INIT  = 6'h01,
    S_IDLE  = 6'h02,
    S_WRITE = 6'h04,
    S_GAP   = 6'h08,
    S_READ  = 6'h10,
    S_END   = 6'h20
  } state_e;

  state_e                            state_r, state_nxt;
  logic [1:0]                        cnt_r, cnt_nxt;
  logic [token_pkg::TOKEN_ADDR_W-1:0] tok_r, tok_nxt;
  logic [1:0]                        cmd_r, cmd_nxt;
  logic                              wbit_r, wbit_nxt;
  logic                              ready_r, ready_nxt;
  logic                              init_r, init_nxt;
  token_pkg::answer_s                ans_r, ans_nxt;
  token_pkg::pins_s                  pins_r, pins_nxt;
  logic [token_pkg::DATA_W-1:0]      data_s1_r, data_s2_r;

  // ==========================================================
  // pin input synchroniser
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_s1_r <= 8'h00;
      data_s2_r <= 8'h00;
    end
    else
    begin
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    tok_nxt   = tok_r;
    cmd_nxt   = cmd_r;
    wbit_nxt  = wbit_r;
    ready_nxt = 1'b0;
    init_nxt  = init_r;
    ans_nxt   = '{owned: ans_r.owned, done: 1'b0};
    pins_nxt  = '{token_space_select_n: 1'b1, write_n: 1'b1, output_enable_n: 1'b1,
                  addr: tok_r, data: 8'h00, data_oe: 1'b0};
    case (state_r)
      S_INIT:
      begin
        // RULE5 free every token
        cmd_nxt   = token_pkg::CMD_INIT;
        wbit_nxt  = 1'b1;
        cnt_nxt   = 2'(token_pkg::SETUP_CYC);
        state_nxt = S_WRITE;
      end
      S_IDLE:
      begin
        ready_nxt = 1'b1;
        if (req_valid_i && ready_r)
        begin
          ready_nxt = 1'b0;
          tok_nxt   = req_i.token;
          cmd_nxt   = req_i.cmd;
          // RULE6 claim writes zero; RULE7 RULE8 release writes one
          wbit_nxt  = (req_i.cmd != token_pkg::CMD_CLAIM);
          cnt_nxt   = 2'(token_pkg::SETUP_CYC);
          state_nxt = (req_i.cmd == token_pkg::CMD_PROBE) ? S_GAP : S_WRITE;
        end
      end
      S_WRITE:
      begin
        // RULE10 RULE11 select low, bit zero carries the flag
        pins_nxt.token_space_select_n = 1'b0;
        pins_nxt.data_oe              = 1'b1;
        pins_nxt.data[token_pkg::FLAG_BIT] = wbit_r;
        pins_nxt.write_n = (cnt_r != token_pkg::CNT_ZERO) ? 1'b1 : 1'b0;
        if (cnt_r != token_pkg::CNT_ZERO)
          cnt_nxt = cnt_r - 2'h1;
        else
        begin
          cnt_nxt   = 2'(token_pkg::STROBE_CYC);
          state_nxt = S_GAP;
        end
        if (cnt_r == token_pkg::CNT_ZERO && pins_r.write_n == 1'b0)
          cnt_nxt = 2'(token_pkg::STROBE_CYC);
      end
      S_GAP:
      begin
        // select drops between cycles so the device read latch reloads
        if (cnt_r != token_pkg::CNT_ZERO)
          cnt_nxt = cnt_r - 2'h1;
        else
        begin
          cnt_nxt   = 2'(token_pkg::STROBE_CYC) + 2'(token_pkg::GAP_CYC);
          state_nxt = (cmd_r == token_pkg::CMD_CLAIM || cmd_r == token_pkg::CMD_PROBE)
                      ? S_READ : S_END;
        end
      end
      S_READ:
      begin
        // RULE12 value held while select and read enable stay low
        pins_nxt.token_space_select_n = 1'b0;
        pins_nxt.output_enable_n      = 1'b0;
        if (cnt_r != token_pkg::CNT_ZERO)
          cnt_nxt = cnt_r - 2'h1;
        else
          state_nxt = S_END;
      end
      S_END:
      begin
        pins_nxt.token_space_select_n = 1'b1;
        if (cmd_r == token_pkg::CMD_INIT)
        begin
          if (tok_r == 3'h7)
          begin
            init_nxt  = 1'b1;
            state_nxt = S_IDLE;
          end
          else
          begin
            tok_nxt   = tok_r + 3'h1;
            state_nxt = S_INIT;
          end
        end
        else
        begin
          // RULE6 RULE14 zero on the flag means this port owns it
          // flag taken here: the device register plus the two-flop path lag the read pins by three cycles
          if (cmd_r == token_pkg::CMD_CLAIM || cmd_r == token_pkg::CMD_PROBE)
            ans_nxt.owned = ~data_s2_r[token_pkg::FLAG_BIT];
          else
            ans_nxt.owned = 1'b0;
          ans_nxt.done = 1'b1;
          state_nxt    = S_IDLE;
        end
      end
      default:
        state_nxt = S_INIT;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= S_INIT;
      cnt_r   <= 2'h0;
      tok_r   <= 3'h0;
      cmd_r   <= 2'h2;
      wbit_r  <= 1'b1;
      ready_r <= 1'b0;
      init_r  <= 1'b0;
      ans_r   <= '0;
      pins_r  <= '{token_space_select_n: 1'b1, write_n: 1'b1, output_enable_n: 1'b1,
                   addr: 3'h0, data: 8'h00, data_oe: 1'b0};
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      tok_r   <= tok_nxt;
      cmd_r   <= cmd_nxt;
      wbit_r  <= wbit_nxt;
      ready_r <= ready_nxt;
      init_r  <= init_nxt;
      ans_r   <= ans_nxt;
      pins_r  <= pins_nxt;
    end
  end

  assign req_ready_o = ready_r;
  assign answer_o    = ans_r;
  assign init_done_o = init_r;
  assign pins_o      = pins_r;

  // ==========================================================
  // checks
  // RULE10 write drives only legal pattern
  write_bit_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
    !pins_o.write_n |-> pins_o.data[7:1] == 7'h00 && !pins_o.token_space_select_n)
    else $error("write drives upper data bits or no select");
  // RULE11 no read and write together
  rw_excl_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE11
    !(!pins_o.write_n && !pins_o.output_enable_n))
    else $error("read and write strobes overlap");
  // RULE5 all tokens freed before ready
  init_first_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE5
    req_ready_o |-> init_done_o)
    else $error("ready before initialisation");
  // RULE6 claim write is followed by a read
  claim_read_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE6
    (!pins_o.write_n && pins_o.data[0] == 1'b0) |-> ##[1:10] !pins_o.output_enable_n)
    else $error("claim write not followed by read");
  // RULE7 release write carries one
  release_one_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
    (!pins_o.write_n && cmd_r == token_pkg::CMD_RELEASE) |-> pins_o.data[0])
    else $error("release did not write one");
  // RULE12 read enable only inside token space
  read_select_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE12
    !pins_o.output_enable_n |-> !pins_o.token_space_select_n && !pins_o.data_oe)
    else $error("read enable outside token space or with host drive");
  // RULE10 host drives data only during a token write
  drive_excl_a: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
    pins_o.data_oe |-> !pins_o.token_space_select_n && pins_o.output_enable_n)
    else $error("data driven outside a token write");
  c_claim: cover property (@(posedge clock_i) answer_o.done && answer_o.owned);
  c_fail:  cover property (@(posedge clock_i) answer_o.done && !answer_o.owned);
  c_init:  cover property (@(posedge clock_i) $rose(init_done_o));
endmodule // token_host
`default_nettype wire

/* token_device.sv */
`timescale 1ns/1ps
`default_nettype none
module token_device (
  // clock
  input  wire logic              clock_i,
  // host port pins
  input  wire token_pkg::pins_s  pins_i,
  output logic [7:0]             data_o,
  // far port, driven by the bench
  input  wire logic              b_we_i,
  input  wire logic [2:0]        b_addr_i,
  input  wire logic              b_d0_i,
  output logic [7:0]             b_own_o
);
  // stuck requests at power-up so the host init has work to do
  // no auto init
  logic [7:0] req_a = 8'h00;
  logic [7:0] req_b = 8'hFF;
  logic [7:0] own_a = 8'hFF;
  logic [7:0] own_b = 8'h00;
  logic       act_r = 1'b0;
  logic       rd;

  initial data_o = 8'hFF;
  assign rd = !pins_i.token_space_select_n && !pins_i.output_enable_n;
  assign b_own_o = own_b;

  // data bit zero, three address bits
  // spread and latch flag while read active
  always @(posedge clock_i)
  begin
    if (!pins_i.token_space_select_n && !pins_i.write_n)
      req_a[pins_i.addr] = pins_i.data[0];
    if (b_we_i)
      req_b[b_addr_i] = b_d0_i;
    for (int t = 0; t < 8; t++)
    begin
      if (own_a[t] && req_a[t])
        own_a[t] = 1'b0;
      if (own_b[t] && req_b[t])
        own_b[t] = 1'b0;
      // a tie goes to the host port; any fixed choice is allowed
      if (!own_a[t] && !own_b[t] && !req_a[t])
        own_a[t] = 1'b1;
      else if (!own_a[t] && !own_b[t] && !req_b[t])
        own_b[t] = 1'b1;
    end
    act_r  <= rd;
    // released bus shows a changing pattern, not the last value
    data_o <= rd ? (act_r ? data_o : {8{~own_a[pins_i.addr]}}) : ~data_o;
  end
endmodule // token_device
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               clock_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               req_valid_i = 1'b0;
  token_pkg::request_s req_i = '0;
  logic               b_we = 1'b0;
  logic               b_d0 = 1'b1;
  logic [2:0]         b_addr = 3'h0;
  logic               req_ready_o;
  logic               init_done_o;
  token_pkg::answer_s answer_o;
  token_pkg::pins_s   pins_o;
  logic [7:0]         data_i;
  logic [7:0]         b_own;
  logic [2:0]         t;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  logic               exp_q[$];

  always #20 clock_i = ~clock_i;

  token_host DUT (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .answer_o(answer_o),
    .init_done_o(init_done_o), .pins_o(pins_o), .data_i(data_i));
  token_device far (.clock_i(clock_i), .pins_i(pins_o), .data_o(data_i),
    .b_we_i(b_we), .b_addr_i(b_addr), .b_d0_i(b_d0), .b_own_o(b_own));

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %0h seen %0h", what, e, s);
    end
  endtask

  task automatic request(logic [1:0] c, logic [2:0] tk, logic e);
    int n;
    n = 0;
    do begin @(negedge clock_i); n++; end while (req_ready_o !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      num_errors++;
      close_out();
    end
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_i <= '{cmd: c, token: tk};
    exp_q.push_back(e);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin @(negedge clock_i); n++; end while (answer_o.done !== 1'b1 && n < 60);
    if (n >= 60)
    begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic b_write(logic [2:0] tk, logic d);
    @(posedge clock_i);
    b_addr <= tk;
    b_d0 <= d;
    b_we <= 1'b1;
    @(posedge clock_i);
    b_we <= 1'b0;
    @(negedge clock_i);
  endtask

  // every answer is matched against the oldest expectation
  always @(negedge clock_i)
  begin
    if (answer_o.done === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spurious answer", 8'h00, 8'h01);
      else
        check("owned", 8'(exp_q.pop_front()), 8'(answer_o.owned));
    end
  end

  initial
  begin
    void'($urandom(32'h00C3));
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int n = 0; n < 300 && init_done_o !== 1'b1; n++)
      @(negedge clock_i);
    check("init done", 8'h01, 8'(init_done_o));
    for (int k = 0; k < 8; k++)
      request(token_pkg::CMD_PROBE, 3'(k), 1'b0);
    request(token_pkg::CMD_CLAIM, 3'h3, 1'b1);
    b_write(3'h3, 1'b0);
    check("far owner", 8'h00, b_own);
    request(token_pkg::CMD_PROBE, 3'h3, 1'b1);
    b_write(3'h5, 1'b0);
    request(token_pkg::CMD_CLAIM, 3'h5, 1'b0);
    request(token_pkg::CMD_RELEASE, 3'h5, 1'b0);
    b_write(3'h5, 1'b1);
    request(token_pkg::CMD_PROBE, 3'h5, 1'b0);
    b_write(3'h6, 1'b0);
    request(token_pkg::CMD_CLAIM, 3'h6, 1'b0);
    b_write(3'h6, 1'b1);
    request(token_pkg::CMD_PROBE, 3'h6, 1'b1);
    request(token_pkg::CMD_RELEASE, 3'h6, 1'b0);
    request(token_pkg::CMD_PROBE, 3'h6, 1'b0);
    request(token_pkg::CMD_RELEASE, 3'h3, 1'b0);
    @(negedge clock_i);
    check("far owner", 8'h08, b_own);
    repeat (6)
    begin
      t = 3'($urandom_range(0, 6));
      if (t == 3'h3)
        t = 3'h7;
      request(token_pkg::CMD_CLAIM, t, 1'b1);
      request(token_pkg::CMD_RELEASE, t, 1'b0);
    end
    close_out();
  end
endmodule // testbench
`default_nettype wire
